// ===== resonant_edge_map.vh
`ifndef RESONANT_EDGE_MAP_VH
`define RESONANT_EDGE_MAP_VH

// register offsets
`define PRIMARY_D_FALL_OFFSET_ADDR    8'h4f
`define RECTIFIER_ONE_RISE_DELAY_ADDR 8'h51
`define RECTIFIER_ONE_FALL_LEAD_ADDR  8'h53

// reset values of the offset codes
`define PRIMARY_D_FALL_OFFSET_RST     8'h00
`define RECTIFIER_ONE_RISE_DELAY_RST  8'h00
`define RECTIFIER_ONE_FALL_LEAD_RST   8'h00

// offset code field
`define OFFSET_CODE_MSB               7
`define OFFSET_CODE_LSB               0

// timing: one code step in ns, clock period in ns
`define OFFSET_STEP_NS                12'h005
`define CLK_PERIOD_NS                 12'h004
`define CLK_PERIOD_HALF_NS            12'h002

`endif

// ===== resonant_edge_dead_time.v
// Functional notes
// - resonant mode: primary drive four falls code*5ns before switching cycle end.
// - resonant mode: rectifier drive one rises code*5ns after ac sense rise.
// - resonant mode: rectifier drive one falls code*5ns before ac sense fall.
// - offset codes are unsigned 8-bit linear, 0 none, 5ns step, max 1275ns.
`include "resonant_edge_map.vh"

module resonant_edge_dead_time (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_b,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_ff,
    // timebase and mode
    input  wire        resonant_mode,
    input  wire [15:0] cycle_pos,
    input  wire [15:0] cycle_len,
    input  wire        primary_four_nominal,
    // ac sense comparator
    input  wire        ac_sense_input,
    // drives
    output reg         primary_drive_four_ff,
    output reg         rectifier_drive_one_ff
);

    reg  [7:0]  primary_four_fall_offset_ff;
    reg  [7:0]  rectifier_one_rise_offset_ff;
    reg  [7:0]  rectifier_one_fall_offset_ff;
    reg         ac_prev_ff;
    reg  [15:0] since_rise_ff;
    reg  [15:0] last_high_ff;

    reg  [7:0]  nxt_rdata;
    reg         nxt_primary;
    reg         nxt_rect;

    wire [9:0]  pri_fall_cyc;
    wire [9:0]  rect_rise_cyc;
    wire [9:0]  rect_fall_cyc;
    wire        sense_rise;
    wire        sense_fall;
    wire [16:0] pri_lead_sum;
    wire [16:0] high_elapsed;
    wire [16:0] rect_lead_sum;
    wire        pri_lead_met;
    wire        rect_rise_met;
    wire        rect_fall_met;
    wire        rect_rise_now;

    // 5 ns steps on a 4 ns clock: round to the nearest cycle, so the edge
    // jitters by at most 2 ns against the ideal position
    function [9:0] to_cycles;
        input [7:0] code;
        reg   [11:0] t_ns;
        begin
            t_ns = {4'h0, code} * `OFFSET_STEP_NS + `CLK_PERIOD_HALF_NS;
            to_cycles = t_ns[11:2];
        end
    endfunction

    // true when the register port addresses the given offset
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // unsigned compare on 17 bits, so a sum near the 16-bit limit
    // cannot wrap and read as not yet reached
    function at_or_past;
        input [16:0] value;
        input [16:0] limit;
        begin
            at_or_past = (value >= limit);
        end
    endfunction

    assign pri_fall_cyc  = to_cycles(primary_four_fall_offset_ff);
    assign rect_rise_cyc = to_cycles(rectifier_one_rise_offset_ff);
    assign rect_fall_cyc = to_cycles(rectifier_one_fall_offset_ff);

    assign sense_rise = ac_sense_input & ~ac_prev_ff;
    assign sense_fall = ~ac_sense_input & ac_prev_ff;

    // since_rise_ff lags the sense edge by one clock; high_elapsed puts it
    // back on the same footing as last_high_ff
    assign pri_lead_sum  = {1'b0, cycle_pos} + {7'h00, pri_fall_cyc};
    assign high_elapsed  = {1'b0, since_rise_ff} + 17'h00001;
    assign rect_lead_sum = high_elapsed + {7'h00, rect_fall_cyc};

    assign pri_lead_met  = at_or_past(pri_lead_sum, {1'b0, cycle_len});
    assign rect_rise_met = at_or_past(high_elapsed, {7'h00, rect_rise_cyc});
    assign rect_fall_met = at_or_past(rect_lead_sum, {1'b0, last_high_ff});
    assign rect_rise_now = sense_rise & (rect_rise_cyc == 10'h000);

    // register writes: one flop bank per offset code, unmapped
    // addresses leave every code untouched
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            primary_four_fall_offset_ff <= `PRIMARY_D_FALL_OFFSET_RST;
        end else if (reg_wr &&
                     addr_hit(reg_addr, `PRIMARY_D_FALL_OFFSET_ADDR)) begin
            primary_four_fall_offset_ff <= reg_wdata;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rectifier_one_rise_offset_ff <= `RECTIFIER_ONE_RISE_DELAY_RST;
        end else if (reg_wr &&
                     addr_hit(reg_addr, `RECTIFIER_ONE_RISE_DELAY_ADDR)) begin
            rectifier_one_rise_offset_ff <= reg_wdata;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rectifier_one_fall_offset_ff <= `RECTIFIER_ONE_FALL_LEAD_RST;
        end else if (reg_wr &&
                     addr_hit(reg_addr, `RECTIFIER_ONE_FALL_LEAD_ADDR)) begin
            rectifier_one_fall_offset_ff <= reg_wdata;
        end
    end

    // read data, unmapped addresses read zero; the word stands one
    // cycle only, so an idle port always shows zero
    always @* begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            if (addr_hit(reg_addr, `PRIMARY_D_FALL_OFFSET_ADDR)) begin
                nxt_rdata = primary_four_fall_offset_ff;
            end else if (addr_hit(reg_addr,
                                  `RECTIFIER_ONE_RISE_DELAY_ADDR)) begin
                nxt_rdata = rectifier_one_rise_offset_ff;
            end else if (addr_hit(reg_addr,
                                  `RECTIFIER_ONE_FALL_LEAD_ADDR)) begin
                nxt_rdata = rectifier_one_fall_offset_ff;
            end
        end
    end

    // sense edge reference: count since the last rise, remember high time
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ac_prev_ff    <= 1'b0;
            since_rise_ff <= 16'h0000;
            last_high_ff  <= 16'h0000;
        end else begin
            ac_prev_ff <= ac_sense_input;
            if (sense_rise) begin
                since_rise_ff <= 16'h0000;
            end else if (since_rise_ff != 16'hffff) begin
                since_rise_ff <= since_rise_ff + 16'h0001;
            end
            // the fall point cannot be seen in advance, so the last high
            // time predicts the next one; a lead needs a steady sense period
            if (sense_fall) begin
                last_high_ff <= since_rise_ff + 16'h0001;
            end
        end
    end

    // primary drive four: nominal level from the timebase, forced low in
    // resonant mode once the lead window before the cycle end is reached
    always @* begin
        nxt_primary = primary_four_nominal;
        if (resonant_mode && pri_lead_met) begin
            nxt_primary = 1'b0;
        end
    end

    // rectifier drive one: a zero rise code turns on in the edge cycle
    // itself, which overrides the predicted fall on purpose
    always @* begin
        nxt_rect = 1'b0;
        if (resonant_mode) begin
            if (ac_sense_input && !sense_rise && rect_rise_met) begin
                nxt_rect = 1'b1;
            end
            if (rect_fall_met) begin
                nxt_rect = 1'b0;
            end
            if (rect_rise_now) begin
                nxt_rect = 1'b1;
            end
        end
    end

    // read data register
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // drive registers: outputs come straight from flops, one clock late
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            primary_drive_four_ff <= 1'b0;
        end else begin
            primary_drive_four_ff <= nxt_primary;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rectifier_drive_one_ff <= 1'b0;
        end else begin
            rectifier_drive_one_ff <= nxt_rect;
        end
    end

endmodule

// ===== ac_sense_model.sv
module ac_sense_model (
    // clock and reset
    input  wire         clk_sys,
    input  wire         rst_b,
    // timebase and comparator
    output logic [15:0] cycle_pos,
    output logic        ac_sense_input,
    output logic        primary_four_nominal
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            cycle_pos <= 16'h0000;
        else
            cycle_pos <= (cycle_pos == 16'h0027) ? 16'h0000
                                                 : cycle_pos + 16'h0001;
    end
    // clean comparator, no chatter: a 20-clock high half of a 40-clock cycle
    assign ac_sense_input = cycle_pos < 16'h0014;
    assign primary_four_nominal = cycle_pos < 16'h0024;
endmodule

// ===== resonant_edge_monitor.sv
module resonant_edge_monitor (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata_ff,
    input wire        resonant_mode,
    input wire [15:0] cycle_pos,
    input wire [15:0] cycle_len,
    input wire        primary_four_nominal,
    input wire        ac_sense_input,
    input wire        primary_drive_four_ff,
    input wire        rectifier_drive_one_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data not zero outside read");
    a_primary_cycle_end: assert property (resonant_mode &&
        cycle_pos == cycle_len - 16'h0001 |=> !primary_drive_four_ff)
        else $error("primary drive high at cycle end");
    a_primary_nominal: assert property (!resonant_mode |=>
        primary_drive_four_ff == $past(primary_four_nominal))
        else $error("primary drive not nominal");
    a_rect_mode_off: assert property (!resonant_mode |=> !rectifier_drive_one_ff)
        else $error("rectifier drive high outside mode");
    a_rect_rise_after: assert property ($rose(rectifier_drive_one_ff) |->
        $past(ac_sense_input))
        else $error("rectifier rose without sense high");
    a_rect_sense_low: assert property (!ac_sense_input |=> !rectifier_drive_one_ff)
        else $error("rectifier high after sense fall");
    c_rect_rise: cover property ($rose(rectifier_drive_one_ff));
    c_primary_fall: cover property (resonant_mode && $fell(primary_drive_four_ff));
    c_reg_read: cover property (reg_rd);
endmodule
bind resonant_edge_dead_time resonant_edge_monitor mon (.*);

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic       resonant_mode = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire  [7:0] reg_rdata_ff;
    wire [15:0] cycle_pos;
    wire        ac_sense_input, primary_four_nominal;
    wire        primary_drive_four_ff, rectifier_drive_one_ff;
    int         fail_count = 0, comparisons = 0, n;
    always #2 clk_sys = ~clk_sys;
    ac_sense_model model (.clk_sys(clk_sys), .rst_b(rst_b),
        .cycle_pos(cycle_pos), .ac_sense_input(ac_sense_input),
        .primary_four_nominal(primary_four_nominal));
    resonant_edge_dead_time dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .resonant_mode(resonant_mode), .cycle_pos(cycle_pos),
        .cycle_len(16'h0028), .primary_four_nominal(primary_four_nominal),
        .ac_sense_input(ac_sense_input),
        .primary_drive_four_ff(primary_drive_four_ff),
        .rectifier_drive_one_ff(rectifier_drive_one_ff));
    task check(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, exp, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        @(negedge clk_sys);
        check(nm, reg_rdata_ff, exp);
    endtask
    task wait_rect(input logic lvl);
        n = 0;
        while (rectifier_drive_one_ff !== lvl && n < 50) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1;
        wr(8'h4f, 8'h08);
        wr(8'h51, 8'h04);
        wr(8'h53, 8'hff);
        rd(8'h4f, 8'h08, "fall code");
        rd(8'h53, 8'hff, "lead code max");
        rd(8'h50, 8'h00, "unmapped");
        wr(8'h53, 8'h08);
        rd(8'h51, 8'h04, "rise code");
        $display("test registers done");
        @(posedge clk_sys);
        resonant_mode <= 1;
        repeat (2) @(posedge ac_sense_input);
        wait_rect(1'b1);
        check("rise delay", n[7:0], 8'h06);
        wait_rect(1'b0);
        check("fall lead", n[7:0], 8'h05);
        check("sense at fall", {7'h00, ac_sense_input}, 8'h01);
        $display("test rectifier done");
        wait (cycle_pos == 16'h001e);
        @(negedge clk_sys);
        check("primary before", {7'h00, primary_drive_four_ff}, 8'h01);
        @(negedge clk_sys);
        check("primary lead", {7'h00, primary_drive_four_ff}, 8'h00);
        $display("test primary done");
        wr(8'h51, 8'h00);
        @(posedge ac_sense_input);
        wait_rect(1'b1);
        check("zero rise delay", n[7:0], 8'h01);
        $display("test zero code done");
        @(posedge clk_sys);
        resonant_mode <= 0;
        repeat (45) @(posedge clk_sys);
        final_report;
    end
    initial begin
        #20000;
        fail_count++;
        final_report;
    end
endmodule
